/* hdl/fault_retry_pkg.sv */
/*
 * Shared constants and carriers for the output-voltage fault retry
 * sequencer and its warning threshold registers.
 * Assumes a PMBus front end that hands over decoded command codes.
 */
package fault_retry_pkg;

    // Command codes of the registers held here
    localparam logic [7:0] CODE_FAULT_RESPONSE = 8'h41;
    localparam logic [7:0] CODE_OV_WARN        = 8'h42;
    localparam logic [7:0] CODE_UV_WARN        = 8'h43;
    localparam logic [7:0] CODE_TIME_UNIT      = 8'hd2;

    // Fault response byte fields
    localparam int RESP_MODE_MSB  = 7;
    localparam int RESP_MODE_LSB  = 6;
    localparam int RESP_RETRY_MSB = 5;
    localparam int RESP_RETRY_LSB = 3;
    localparam int RESP_DELAY_MSB = 2;
    localparam int RESP_DELAY_LSB = 0;

    // Response modes and retry codes
    localparam logic [1:0] MODE_IGNORE  = 2'h0;
    localparam logic [1:0] MODE_DELAY   = 2'h1;
    localparam logic [1:0] MODE_RETRY   = 2'h2;
    localparam logic [1:0] MODE_DISABLE = 2'h3;
    localparam logic [2:0] RETRY_NONE   = 3'h0;
    localparam logic [2:0] RETRY_ALWAYS = 3'h7;

    // Reset values
    localparam logic [7:0]  RESET_FAULT_RESPONSE = 8'h80;
    localparam logic [7:0]  RESET_TIME_UNIT      = 8'h00;
    localparam logic [15:0] RESET_OV_WARN        = 16'hffff;
    localparam logic [15:0] RESET_UV_WARN        = 16'h0000;

    // One base tick of the time unit: 1000 ns at a 100 ns clock
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int BASE_TICK_NS    = 1000;
    localparam int BASE_TICK_CYCLES = (BASE_TICK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // Sequencer states, Gray along the retry path
    typedef enum logic [2:0] {
        ST_OFF   = 3'h0,
        ST_RUN   = 3'h1,
        ST_DELAY = 3'h3,
        ST_GAP   = 3'h2,
        ST_TRY   = 3'h6,
        ST_HOLD  = 3'h7,
        ST_LATCH = 3'h5
    } seq_state_t;

    // Decoded command from the PMBus front end
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        word;
        logic [7:0]  code;
        logic [15:0] wdata;
    } pmbus_cmd_t;

endpackage

/* hdl/fault_retry_seq.sv */
/*
 * Output-voltage fault retry sequencer with over/under-voltage warning
 * thresholds, reached by PMBus command code through a decoded port.
 * Assumes: the PMBus front end, operation command, other-fault shutdown
 * and measurement samples come from logic on mclk; the fault, control
 * and bias pins are asynchronous and are synchronised here.
 */
//
// Notes on behaviour
// (RULE_01) Retry codes 4, 5, 6 allow exactly that many restart attempts.
// (RULE_02) Failed last attempt disables output until the fault is cleared.
// (RULE_03) Restart starts are spaced by delay count times the time unit.
// (RULE_04) Retry code 7 restarts without limit.
// (RULE_05) Continuous retry ends on command off, bias loss or other fault.
// (RULE_06) Low three bits of the response byte are an encoded unit count.
// (RULE_07) One delay count serves as run-on time and as restart spacing.
// (RULE_08) Delay codes map to 1, 2, 8, 16, 32, 64, 128 units.
// (RULE_09) Unit length comes from the time-unit register at code 0xD2.
// (RULE_10) Over-voltage warning threshold is 16 bits at code 0x42.
// (RULE_11) Under-voltage warning threshold is 16 bits at code 0x43.
// (RULE_12) Both thresholds accept read-word and write-word transfers.
// (RULE_13) Top two response bits pick ignore, delay, disable-retry, or hold.
// (RULE_14) Retry code zero leaves output off with no restart.
// (RULE_15) Latched fault clears by bit, clear command, reset, on-off or bias.
// (RULE_16) Delay code 1 counts as one unit.
// (RULE_17) Samples above or below thresholds raise the warning flags.
`timescale 1ns/100ps
module fault_retry_seq #(
    parameter int UNIT_BASE_CYCLES = fault_retry_pkg::BASE_TICK_CYCLES,
    parameter int TIMER_W          = 24
) (
    // Clock, reset, enable
    input  wire logic                        mclk,
    input  wire logic                        resetn,
    input  wire logic                        ce,
    // Command port
    input  wire fault_retry_pkg::pmbus_cmd_t cmd,
    output logic                             rd_valid,
    output logic [15:0]                      rd_data,
    output logic                             cmd_error,
    // Pins and control
    input  wire logic                        fault_pin,
    input  wire logic                        ctrl_on_pin,
    input  wire logic                        bias_ok_pin,
    input  wire logic                        operation_on,
    input  wire logic                        other_fault,
    input  wire logic                        clear_faults,
    input  wire logic                        clear_fault_bit,
    // Measurement
    input  wire logic                        sample_valid,
    input  wire logic [15:0]                 sample,
    // Status and power stage
    output logic                             output_enable,
    output logic                             fault_status,
    output logic                             ov_warning,
    output logic                             uv_warning
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and synchronisers

    logic [7:0]                  fault_response;
    logic [7:0]                  time_unit;
    logic [15:0]                 ov_threshold;
    logic [15:0]                 uv_threshold;
    logic [2:0]                  pin_meta;
    logic [2:0]                  pin_sync;
    fault_retry_pkg::seq_state_t state;
    logic [TIMER_W-1:0]          timer;
    logic [2:0]                  attempts;

    logic       fault_s;
    logic       cmd_on;
    logic [1:0] mode;
    logic [2:0] retries;
    logic [2:0] delay_code;
    logic [7:0] units;
    logic [TIMER_W-1:0] interval_cycles;
    logic       retry_limit_hit;
    logic       wr_ok;
    logic       rd_ok;

    // Two flops on every pin; only the second stage is read
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else if (ce) begin
            pin_meta <= {bias_ok_pin, ctrl_on_pin, fault_pin};
            pin_sync <= pin_meta;
        end
    end

    assign fault_s    = pin_sync[0];
    // (RULE_05) on command
    assign cmd_on     = pin_sync[1] & operation_on & pin_sync[2];
    // (RULE_13) mode field
    assign mode       = fault_response[fault_retry_pkg::RESP_MODE_MSB:fault_retry_pkg::RESP_MODE_LSB];
    assign retries    = fault_response[fault_retry_pkg::RESP_RETRY_MSB:fault_retry_pkg::RESP_RETRY_LSB];
    // (RULE_06) encoded delay field
    assign delay_code = fault_response[fault_retry_pkg::RESP_DELAY_MSB:fault_retry_pkg::RESP_DELAY_LSB];

    // (RULE_08) delay decode
    // (RULE_16) code 1 as one unit
    always_comb begin
        unique case (delay_code)
            3'h0, 3'h1: units = 8'h01;
            3'h2:       units = 8'h02;
            3'h3:       units = 8'h08;
            3'h4:       units = 8'h10;
            3'h5:       units = 8'h20;
            3'h6:       units = 8'h40;
            3'h7:       units = 8'h80;
        endcase
    end

    // (RULE_09) unit length from time unit
    // A time_unit value of n stretches one unit to n+1 base ticks
    assign interval_cycles = TIMER_W'(units * (time_unit + 9'h001) * UNIT_BASE_CYCLES - 1);

    // (RULE_01) finite retry budget spent
    assign retry_limit_hit = (retries != fault_retry_pkg::RETRY_ALWAYS) && (attempts >= retries);

    ////////////////////////////////////////////////////////////////////////
    // Register access

    // (RULE_12) word access to thresholds, byte access to the rest
    always_comb begin
        unique case (cmd.code)
            fault_retry_pkg::CODE_OV_WARN,
            fault_retry_pkg::CODE_UV_WARN:        wr_ok = cmd.word;
            fault_retry_pkg::CODE_FAULT_RESPONSE,
            fault_retry_pkg::CODE_TIME_UNIT:      wr_ok = !cmd.word;
            default:                              wr_ok = 1'b0;
        endcase
    end
    assign rd_ok = wr_ok;

    // Writes; a mismatched size is refused whole
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            fault_response <= fault_retry_pkg::RESET_FAULT_RESPONSE;
            time_unit      <= fault_retry_pkg::RESET_TIME_UNIT;
            ov_threshold   <= fault_retry_pkg::RESET_OV_WARN;
            uv_threshold   <= fault_retry_pkg::RESET_UV_WARN;
        end else if (ce && cmd.valid && cmd.write && wr_ok) begin
            unique case (cmd.code)
                // (RULE_10) over-voltage threshold
                fault_retry_pkg::CODE_OV_WARN:        ov_threshold   <= cmd.wdata;
                // (RULE_11) under-voltage threshold
                fault_retry_pkg::CODE_UV_WARN:        uv_threshold   <= cmd.wdata;
                fault_retry_pkg::CODE_FAULT_RESPONSE: fault_response <= cmd.wdata[7:0];
                default:                              time_unit      <= cmd.wdata[7:0];
            endcase
        end
    end

    // Read answer one cycle after the request; error pulse on refusal
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rd_valid  <= 1'b0;
            rd_data   <= 16'h0000;
            cmd_error <= 1'b0;
        end else if (ce) begin
            rd_valid  <= cmd.valid && !cmd.write && rd_ok;
            cmd_error <= cmd.valid && !wr_ok;
            if (cmd.valid && !cmd.write && rd_ok) begin
                unique case (cmd.code)
                    fault_retry_pkg::CODE_OV_WARN:        rd_data <= ov_threshold;
                    fault_retry_pkg::CODE_UV_WARN:        rd_data <= uv_threshold;
                    fault_retry_pkg::CODE_FAULT_RESPONSE: rd_data <= {8'h00, fault_response};
                    default:                              rd_data <= {8'h00, time_unit};
                endcase
            end else begin
                rd_data <= 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Retry sequencer

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state    <= fault_retry_pkg::ST_OFF;
            timer    <= '0;
            attempts <= 3'h0;
        end else if (ce) begin
            if (timer != '0) begin
                timer <= timer - TIMER_W'(1);
            end
            if (!cmd_on) begin
                // (RULE_05) commanded off or bias lost
                // (RULE_15) passing through off clears the latch
                state <= fault_retry_pkg::ST_OFF;
            end else if (other_fault) begin
                // (RULE_05) another fault shuts down
                state <= fault_retry_pkg::ST_LATCH;
            end else begin
                unique case (state)
                    fault_retry_pkg::ST_OFF: begin
                        state    <= fault_retry_pkg::ST_RUN;
                        attempts <= 3'h0;
                    end
                    fault_retry_pkg::ST_RUN: begin
                        attempts <= 3'h0;
                        if (fault_s) begin
                            // (RULE_13) response select
                            unique case (mode)
                                fault_retry_pkg::MODE_IGNORE: state <= fault_retry_pkg::ST_RUN;
                                fault_retry_pkg::MODE_DELAY: begin
                                    // (RULE_07) delay used as run-on time
                                    state <= fault_retry_pkg::ST_DELAY;
                                    timer <= interval_cycles;
                                end
                                fault_retry_pkg::MODE_RETRY: begin
                                    // (RULE_14) no retry latches off
                                    state <= (retries == fault_retry_pkg::RETRY_NONE)
                                           ? fault_retry_pkg::ST_LATCH : fault_retry_pkg::ST_GAP;
                                    timer <= interval_cycles;
                                end
                                default: state <= fault_retry_pkg::ST_HOLD;
                            endcase
                        end
                    end
                    fault_retry_pkg::ST_DELAY: begin
                        if (!fault_s) begin
                            state <= fault_retry_pkg::ST_RUN;
                        end else if (timer == '0) begin
                            state <= (retries == fault_retry_pkg::RETRY_NONE)
                                   ? fault_retry_pkg::ST_LATCH : fault_retry_pkg::ST_GAP;
                            timer <= interval_cycles;
                        end
                    end
                    fault_retry_pkg::ST_GAP: begin
                        // (RULE_03) next start when the interval runs out
                        // (RULE_07) same count spaces restarts
                        if (timer == '0) begin
                            state    <= fault_retry_pkg::ST_TRY;
                            timer    <= interval_cycles;
                            attempts <= (attempts == fault_retry_pkg::RETRY_ALWAYS)
                                      ? attempts : attempts + 3'h1;
                        end
                    end
                    fault_retry_pkg::ST_TRY: begin
                        if (fault_s) begin
                            // (RULE_02) last attempt failed
                            // (RULE_04) code 7 never hits the limit
                            state <= retry_limit_hit ? fault_retry_pkg::ST_LATCH
                                                     : fault_retry_pkg::ST_GAP;
                        end else if (timer == '0) begin
                            state <= fault_retry_pkg::ST_RUN;
                        end
                    end
                    fault_retry_pkg::ST_HOLD: begin
                        // Resumes by itself once the fault is gone
                        if (!fault_s) begin
                            state <= fault_retry_pkg::ST_RUN;
                        end
                    end
                    fault_retry_pkg::ST_LATCH: begin
                        // (RULE_15) bit or clear command releases
                        if (clear_faults || clear_fault_bit) begin
                            state <= fault_retry_pkg::ST_OFF;
                        end
                    end
                    default: state <= fault_retry_pkg::ST_OFF;
                endcase
            end
        end
    end

    // Power stage follows the state one cycle later
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            output_enable <= 1'b0;
        end else if (ce) begin
            output_enable <= (state == fault_retry_pkg::ST_RUN)
                          || (state == fault_retry_pkg::ST_DELAY)
                          || (state == fault_retry_pkg::ST_TRY);
        end
    end

    // Sticky fault flag; a new fault outranks a clear
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            fault_status <= 1'b0;
        end else if (ce) begin
            if (fault_s && mode != fault_retry_pkg::MODE_IGNORE) begin
                fault_status <= 1'b1;
            end else if (clear_faults || clear_fault_bit || !cmd_on) begin
                fault_status <= 1'b0;
            end
        end
    end

    // (RULE_17) warning compare, set wins over clear
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ov_warning <= 1'b0;
            uv_warning <= 1'b0;
        end else if (ce) begin
            if (sample_valid && sample > ov_threshold) begin
                ov_warning <= 1'b1;
            end else if (clear_faults) begin
                ov_warning <= 1'b0;
            end
            if (sample_valid && sample < uv_threshold) begin
                uv_warning <= 1'b1;
            end else if (clear_faults) begin
                uv_warning <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_go;
        ce && cmd_on && !other_fault;
    endsequence
    sequence s_try_fail;
        s_go ##0 state == fault_retry_pkg::ST_TRY && fault_s;
    endsequence

    property p_retry_budget;
        @(posedge mclk) disable iff (!resetn)
        (state == fault_retry_pkg::ST_TRY && retries >= 3'h4 && retries <= 3'h6)
            |-> attempts <= retries && attempts != 3'h0;
    endproperty
    a_retry_budget: assert property (p_retry_budget) else $error("too many attempts"); // RULE_01

    property p_last_fail;
        @(posedge mclk) disable iff (!resetn)
        (s_try_fail ##0 retry_limit_hit) |=> state == fault_retry_pkg::ST_LATCH
            ##1 (!ce || !output_enable);
    endproperty
    a_last_fail: assert property (p_last_fail) else $error("no latch after last attempt"); // RULE_02

    property p_gap_start;
        @(posedge mclk) disable iff (!resetn)
        (s_go ##0 state == fault_retry_pkg::ST_GAP && timer == '0)
            |=> state == fault_retry_pkg::ST_TRY && timer == $past(interval_cycles);
    endproperty
    a_gap_start: assert property (p_gap_start) else $error("restart not on interval"); // RULE_03

    property p_continuous;
        @(posedge mclk) disable iff (!resetn)
        (s_try_fail ##0 retries == fault_retry_pkg::RETRY_ALWAYS)
            |=> state == fault_retry_pkg::ST_GAP;
    endproperty
    a_continuous: assert property (p_continuous) else $error("continuous retry stopped"); // RULE_04

    property p_stop;
        @(posedge mclk) disable iff (!resetn)
        (ce && !cmd_on) |=> state == fault_retry_pkg::ST_OFF ##1 (!ce || !output_enable);
    endproperty
    a_stop: assert property (p_stop) else $error("output not off when commanded"); // RULE_05

    property p_delay_load;
        @(posedge mclk) disable iff (!resetn)
        (s_go ##0 state == fault_retry_pkg::ST_RUN && fault_s && mode == fault_retry_pkg::MODE_DELAY)
            |=> state == fault_retry_pkg::ST_DELAY && timer == $past(interval_cycles);
    endproperty
    a_delay_load: assert property (p_delay_load) else $error("run-on time wrong"); // RULE_07

    property p_no_retry;
        @(posedge mclk) disable iff (!resetn)
        (s_go ##0 state == fault_retry_pkg::ST_RUN && fault_s
            && mode == fault_retry_pkg::MODE_RETRY && retries == fault_retry_pkg::RETRY_NONE)
            |=> state == fault_retry_pkg::ST_LATCH;
    endproperty
    a_no_retry: assert property (p_no_retry) else $error("restart with zero retries"); // RULE_14

    property p_clear;
        @(posedge mclk) disable iff (!resetn)
        (s_go ##0 state == fault_retry_pkg::ST_LATCH && clear_faults)
            |=> state == fault_retry_pkg::ST_OFF;
    endproperty
    a_clear: assert property (p_clear) else $error("latch not cleared"); // RULE_15

    property p_ov_warn;
        @(posedge mclk) disable iff (!resetn)
        (ce && sample_valid && sample > ov_threshold) |=> ov_warning;
    endproperty
    a_ov_warn: assert property (p_ov_warn) else $error("over-voltage warning missed"); // RULE_17

    property p_read_ov;
        @(posedge mclk) disable iff (!resetn)
        (ce && cmd.valid && !cmd.write && cmd.word && cmd.code == fault_retry_pkg::CODE_OV_WARN)
            |=> rd_valid && rd_data == $past(ov_threshold);
    endproperty
    a_read_ov: assert property (p_read_ov) else $error("threshold read wrong"); // RULE_12

endmodule

/* tb/pmbus_host_model.sv */
/*
 * Host model that issues decoded PMBus commands to the retry block.
 * Assumes the block shares mclk and answers a read on the same edge that takes it.
 */
`timescale 1ns/100ps
module pmbus_host_model (
    // Clock
    input  wire logic                   mclk,
    // Command port
    output fault_retry_pkg::pmbus_cmd_t cmd,
    input  wire logic                   rd_valid,
    input  wire logic [15:0]            rd_data,
    input  wire logic                   cmd_error
);
    ////////////////////////////////////////////////////////////////////////
    // Idle until the first request
    initial cmd = '0;

    // word and byte
    // Held to the taking edge, then released to the inverse so no stale value shows
    task automatic xfer(input logic wr, input logic wd, input logic [7:0] code,
                        input logic [15:0] wdata, output logic [15:0] rdata,
                        output logic err);
        @(posedge mclk);
        cmd <= {1'b1, wr, wd, code, wdata};
        @(posedge mclk);
        cmd <= ~{1'b1, wr, wd, code, wdata};
        #1;
        rdata = rd_valid ? rd_data : 16'hdead;
        err = cmd_error;
    endtask
endmodule

/* tb/testbench.sv */
/*
 * Self-checking bench for the fault retry sequencer and warning registers.
 * Assumes UNIT_BASE_CYCLES of 2, so one time unit is 2*(register+1) cycles.
 */
`timescale 1ns/100ps
module testbench;
    logic                        mclk, resetn, fault_pin, ctrl_on_pin, operation_on, other_fault;
    logic                        clear_faults, sample_valid, rd_valid, cmd_error;
    logic                        output_enable, fault_status, ov_warning, uv_warning;
    logic                        er, last;
    logic [15:0]                 sample, rd_data, rd;
    fault_retry_pkg::pmbus_cmd_t cmd;
    int                          error_cnt = 0, compares = 0, rises, gap, fall;
    int                          units[8] = '{1, 1, 2, 8, 16, 32, 64, 128};

    ////////////////////////////////////////////////////////////////////////
    // Block, host and clock
    fault_retry_seq #(.UNIT_BASE_CYCLES(2)) dut_u (.mclk(mclk), .resetn(resetn),
        .ce(1'b1), .cmd(cmd), .rd_valid(rd_valid), .rd_data(rd_data),
        .cmd_error(cmd_error), .fault_pin(fault_pin), .ctrl_on_pin(ctrl_on_pin),
        .bias_ok_pin(1'b1), .operation_on(operation_on), .other_fault(other_fault),
        .clear_faults(clear_faults), .clear_fault_bit(1'b0),
        .sample_valid(sample_valid), .sample(sample), .output_enable(output_enable),
        .fault_status(fault_status), .ov_warning(ov_warning), .uv_warning(uv_warning));
    pmbus_host_model host_u (.mclk(mclk), .cmd(cmd), .rd_valid(rd_valid),
        .rd_data(rd_data), .cmd_error(cmd_error));
    initial begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (error_cnt == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Pulse the clear command and let the sequencer settle
    // Waits first: a fault still in the synchroniser would win over the clear
    task automatic pulse_clear();
        repeat (3) @(posedge mclk);
        @(posedge mclk) clear_faults <= 1'b1;
        @(posedge mclk) clear_faults <= 1'b0;
        repeat (12) @(posedge mclk);
    endtask

    // Hold a fault for win cycles, tallying output restarts and spacing
    // Stop 1 turns the control pin off, stop 2 raises another fault
    task automatic run_fault(input logic [7:0] resp, input int win, input int stop);
        host_u.xfer(1, 0, 8'h41, {8'h00, resp}, rd, er);
        @(posedge mclk) fault_pin <= 1'b1;
        rises = 0; gap = -1; fall = -1;
        for (int i = 0, r1 = 0, p = 1; i < win; i++) begin
            @(posedge mclk) #1;
            if (output_enable !== 1 && fall < 0) fall = i;
            if (output_enable === 1 && p == 0) begin
                rises++;
                if (rises == 1) r1 = i;
                if (rises == 2) gap = i - r1;
            end
            p = (output_enable === 1);
        end
        last = output_enable;
        check(fault_status, resp[7:6] != 2'h0);
        if (stop != 0) begin
            @(posedge mclk) begin
                if (stop == 1) ctrl_on_pin <= 1'b0;
                else other_fault <= 1'b1;
            end
            repeat (4) @(posedge mclk);
            #1 check(output_enable, 0);
            @(posedge mclk) #1 check(output_enable, 0);
            @(posedge mclk) {ctrl_on_pin, other_fault} <= 2'b10;
        end
        @(posedge mclk) fault_pin <= 1'b0;
        pulse_clear();
        check(output_enable, 1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Threshold registers: reset values, word access, size refusal
    task automatic regs();
        host_u.xfer(0, 1, 8'h42, 16'h0000, rd, er); check(rd, 16'hffff);
        host_u.xfer(0, 1, 8'h43, 16'h0000, rd, er); check(rd, 16'h0000);
        host_u.xfer(1, 1, 8'h42, 16'h1234, rd, er);
        host_u.xfer(1, 1, 8'h43, 16'h0abc, rd, er);
        host_u.xfer(0, 1, 8'h42, 16'h0000, rd, er); check(rd, 16'h1234);
        host_u.xfer(0, 1, 8'h43, 16'h0000, rd, er); check(rd, 16'h0abc);
        host_u.xfer(0, 0, 8'h42, 16'h0000, rd, er); check({rd, er}, {16'hdead, 1'b1});
    endtask

    // Samples outside the thresholds raise the matching warning
    task automatic warn(input logic [15:0] v, input logic ov, input logic uv);
        @(posedge mclk) {sample_valid, sample} <= {1'b1, v};
        @(posedge mclk) {sample_valid, sample} <= {1'b0, ~v};
        repeat (2) @(posedge mclk);
        #1 check({ov_warning, uv_warning}, {ov, uv});
        pulse_clear();
    endtask

    // Restart counts, limits and spacing
    task automatic retries();
        for (int n = 4; n <= 6; n++) begin
            run_fault({2'b10, n[2:0], 3'h0}, 300, 0);
            check(rises, n);
            check(last, 0);
        end
        run_fault(8'h80, 100, 0); check(rises, 0);
        run_fault(8'hb8, 300, 1); check(rises >= 20, 1);
        run_fault(8'hb8, 100, 2); check(rises >= 20, 1);
        // Two base cycles per unit in this bench
        for (int d = 0; d < 8; d++) begin
            run_fault({5'b10010, d[2:0]}, 600, 0);
            check(gap, 2 * units[d]);
        end
        host_u.xfer(1, 0, 8'hd2, 16'h0001, rd, er);
        run_fault(8'h93, 100, 0); check(gap, 32);
        host_u.xfer(1, 0, 8'hd2, 16'h0000, rd, er);
    endtask

    // Response modes: ignore, delay-then-act, hold while present
    task automatic modes();
        run_fault(8'h00, 60, 0); check(fall < 0, 1);
        run_fault(8'hc0, 60, 0); check(rises, 0);
        check(last, 0);
        // Sixteen-cycle run-on plus sync and register stages
        run_fault(8'h43, 60, 0); check(fall, 19);
        check(rises, 0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        resetn = 0; fault_pin = 0; ctrl_on_pin = 1; operation_on = 1; other_fault = 0;
        clear_faults = 0; sample_valid = 0; sample = 16'h0000;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        regs();
        for (int i = 0; i < 20 && output_enable !== 1; i++) @(posedge mclk) #1;
        check(output_enable, 1);
        if (output_enable !== 1) results();
        warn(16'h1235, 1, 0);
        warn(16'h0abb, 0, 1);
        warn(16'h1000, 0, 0);
        retries();
        modes();
        results();
    end
endmodule
